// ===== common/alu_pkg.sv
// package: opcodes, carriers, offsets and reset values for the byte alu slice
package alu_pkg;

  // ----------------------------------------------------------------
  // operation codes
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    OP_NONE = 3'h0,
    OP_SUB_WORK_FROM_FILE = 3'h1,
    OP_SUB_WORK_FROM_LITERAL = 3'h2,
    OP_XOR_LITERAL_INTO_WORK = 3'h3,
    OP_XOR_WORK_WITH_FILE = 3'h4,
    OP_SWAP_FILE_NIBBLES = 3'h5
  } alu_op_e;

  // ----------------------------------------------------------------
  // avalon register map (byte addresses)
  // ----------------------------------------------------------------
  localparam int ADDR_W = 4;
  localparam logic [ADDR_W-1:0] OFS_CTRL = 4'h0;
  localparam logic [ADDR_W-1:0] OFS_WORK = 4'h4;
  localparam logic [ADDR_W-1:0] OFS_STATUS = 4'h8;
  localparam logic [ADDR_W-1:0] OFS_FILE_OUT = 4'hC;

  // ctrl register fields
  localparam int CTRL_OP_LSB = 0;
  localparam int CTRL_DEST_BIT = 3;
  localparam int CTRL_LIT_LSB = 8;
  localparam int CTRL_FILE_LSB = 16;
  localparam int CTRL_GO_BIT = 24;

  // status register fields
  localparam int STAT_CARRY_BIT = 0;
  localparam int STAT_DIGIT_BIT = 1;
  localparam int STAT_ZERO_BIT = 2;
  localparam int STAT_FILE_WR_BIT = 3;

  // destination select values
  localparam logic DEST_WORK = 1'b0;
  localparam logic DEST_FILE = 1'b1;

  // reset values
  localparam logic [7:0] WORK_RESET = 8'h00;
  localparam logic [7:0] BYTE_ZERO = 8'h00;

  // ----------------------------------------------------------------
  // carriers
  // ----------------------------------------------------------------
  typedef struct packed {
    alu_op_e op;
    logic dest;
    logic [7:0] literal;
    logic [7:0] file_val;
    logic [7:0] work_val;
  } alu_req_s;

  typedef struct packed {
    logic [7:0] result;
    logic to_file;
    logic to_work;
    logic carry_we;
    logic carry;
    logic digit_we;
    logic digit;
    logic zero_we;
    logic zero;
  } alu_res_s;

endpackage

// ===== hw/alu_core.sv
// combinational byte datapath: subtract, xor and nibble swap
`timescale 1ns/1ps
`default_nettype none
module alu_core (
  // request
  input wire alu_pkg::alu_req_s req,
  // result
  output alu_pkg::alu_res_s res
);
  logic [8:0] diff;
  logic [4:0] ndiff;
  logic [7:0] a_val;

  always_comb begin
    // minuend is file or literal, subtrahend is work
    a_val = (req.op == alu_pkg::OP_SUB_WORK_FROM_LITERAL) ? req.literal : req.file_val;
    // no-borrow carry: 9-bit sum of a and two's complement of work
    diff = {1'b0, a_val} + {1'b0, ~req.work_val} + 9'h001;
    ndiff = {1'b0, a_val[3:0]} + {1'b0, ~req.work_val[3:0]} + 5'h01;
    res = '0;
    case (req.op)
      alu_pkg::OP_SUB_WORK_FROM_FILE: begin
        res.result = diff[7:0];
        res.to_work = (req.dest == alu_pkg::DEST_WORK);
        res.to_file = (req.dest == alu_pkg::DEST_FILE);
        res.carry_we = 1'b1;
        res.carry = diff[8];
        res.digit_we = 1'b1;
        res.digit = ndiff[4];
        res.zero_we = 1'b1;
      end
      alu_pkg::OP_SUB_WORK_FROM_LITERAL: begin
        res.result = diff[7:0];
        res.to_work = 1'b1;
        res.carry_we = 1'b1;
        res.carry = diff[8];
        res.digit_we = 1'b1;
        res.digit = ndiff[4];
        res.zero_we = 1'b1;
      end
      alu_pkg::OP_XOR_LITERAL_INTO_WORK: begin
        res.result = req.work_val ^ req.literal;
        res.to_work = 1'b1;
        res.zero_we = 1'b1;
      end
      alu_pkg::OP_XOR_WORK_WITH_FILE: begin
        res.result = req.work_val ^ req.file_val;
        res.to_work = (req.dest == alu_pkg::DEST_WORK);
        res.to_file = (req.dest == alu_pkg::DEST_FILE);
        res.zero_we = 1'b1;
      end
      alu_pkg::OP_SWAP_FILE_NIBBLES: begin
        res.result = {req.file_val[3:0], req.file_val[7:4]};
        res.to_work = (req.dest == alu_pkg::DEST_WORK);
        res.to_file = (req.dest == alu_pkg::DEST_FILE);
      end
      default: begin
        res.result = alu_pkg::BYTE_ZERO;
      end
    endcase
    res.zero = (res.result == alu_pkg::BYTE_ZERO);
  end
endmodule // alu_core
`default_nettype wire

// ===== hw/byte_alu_sub_xor_swap.sv
// top: byte alu slice with working register, flags and avalon-mm slave
`timescale 1ns/1ps
`default_nettype none
// Overview of operation
// - file subtract: file minus work, to work if dest 0, file if 1
// - file subtract sets carry, digit carry and zero as no-borrow bits
// - literal xor: work xor immediate into work, only zero changes
// - swap: exchange nibbles of file value, dest bit steers, no flags
// - file xor: work xor file, steered by dest bit, only zero changes
// - literal subtract: immediate minus work into work, sets carry, digit, zero
module byte_alu_sub_xor_swap (
  // clock and reset
  input wire logic CLK_SYS,
  input wire logic SRST,
  // decoder strobe and operands
  input wire logic OP_VALID,
  input wire logic [2:0] OP_CODE,
  input wire logic OP_DEST,
  input wire logic [7:0] OP_LITERAL,
  input wire logic [7:0] FILE_RDATA,
  // file write-back
  output logic FILE_WE,
  output logic [7:0] FILE_WDATA,
  // working register and flags
  output logic [7:0] WORK,
  output logic CARRY,
  output logic DIGIT_CARRY,
  output logic ZERO,
  // avalon-mm slave
  input wire logic [3:0] AVS_ADDRESS,
  input wire logic AVS_READ,
  input wire logic AVS_WRITE,
  input wire logic [31:0] AVS_WRITEDATA,
  input wire logic [3:0] AVS_BYTEENABLE,
  output logic [31:0] AVS_READDATA,
  output logic AVS_WAITREQUEST
);
  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  logic [7:0] work_q;
  logic carry_q, digit_carry_flag_q, zero_q;
  logic file_we_q;
  logic [7:0] file_wdata_q;
  logic [31:0] ctrl_q;
  logic [31:0] rdata_q;
  logic ack_q;
  logic sw_go;
  logic [7:0] sw_work;
  logic sw_work_we;
  alu_pkg::alu_req_s req;
  alu_pkg::alu_res_s res;
  logic fire;

  // ----------------------------------------------------------------
  // operation select: decoder strobe wins over a software go
  // ----------------------------------------------------------------
  always_comb begin
    req = '0;
    fire = OP_VALID | sw_go;
    req.work_val = work_q;
    if (OP_VALID) begin
      req.op = alu_pkg::alu_op_e'(OP_CODE);
      req.dest = OP_DEST;
      req.literal = OP_LITERAL;
      req.file_val = FILE_RDATA;
    end else begin
      req.op = alu_pkg::alu_op_e'(ctrl_q[alu_pkg::CTRL_OP_LSB +: 3]);
      req.dest = ctrl_q[alu_pkg::CTRL_DEST_BIT];
      req.literal = ctrl_q[alu_pkg::CTRL_LIT_LSB +: 8];
      req.file_val = ctrl_q[alu_pkg::CTRL_FILE_LSB +: 8];
    end
  end

  alu_core u_core (
    .req(req),
    .res(res)
  );

  // ----------------------------------------------------------------
  // working register and flags
  // ----------------------------------------------------------------
  always_ff @(posedge CLK_SYS) begin
    if (SRST) begin
      work_q <= alu_pkg::WORK_RESET;
    end else if (fire && res.to_work) begin
      work_q <= res.result;
    end else if (sw_work_we) begin
      work_q <= sw_work;
    end
  end

  always_ff @(posedge CLK_SYS) begin
    if (SRST) begin
      carry_q <= 1'b0;
      digit_carry_flag_q <= 1'b0;
      zero_q <= 1'b0;
    end else if (fire) begin
      if (res.carry_we) begin
        carry_q <= res.carry;
      end
      if (res.digit_we) begin
        digit_carry_flag_q <= res.digit;
      end
      if (res.zero_we) begin
        zero_q <= res.zero;
      end
    end
  end

  // file write-back is a one-cycle pulse after the operation
  always_ff @(posedge CLK_SYS) begin
    if (SRST) begin
      file_we_q <= 1'b0;
      file_wdata_q <= alu_pkg::BYTE_ZERO;
    end else begin
      file_we_q <= fire & res.to_file;
      if (fire && res.to_file) begin
        file_wdata_q <= res.result;
      end
    end
  end

  // ----------------------------------------------------------------
  // avalon slave: one wait cycle, answer at the second edge
  // ----------------------------------------------------------------
  logic req_act;
  assign req_act = (AVS_READ | AVS_WRITE) & ~ack_q;

  always_ff @(posedge CLK_SYS) begin
    if (SRST) begin
      ack_q <= 1'b0;
    end else begin
      ack_q <= req_act;
    end
  end

  // write takes effect on the edge where waitrequest is seen low
  always_comb begin
    sw_go = 1'b0;
    sw_work_we = 1'b0;
    sw_work = AVS_WRITEDATA[7:0];
    if (ack_q && AVS_WRITE && !OP_VALID) begin
      if (AVS_ADDRESS == alu_pkg::OFS_CTRL && AVS_BYTEENABLE[3]) begin
        sw_go = AVS_WRITEDATA[alu_pkg::CTRL_GO_BIT];
      end
      if (AVS_ADDRESS == alu_pkg::OFS_WORK && AVS_BYTEENABLE[0]) begin
        sw_work_we = 1'b1;
      end
    end
  end

  // go sees the old ctrl fields; write fields first, then set go
  always_ff @(posedge CLK_SYS) begin
    if (SRST) begin
      ctrl_q <= 32'h0000_0000;
    end else if (ack_q && AVS_WRITE && AVS_ADDRESS == alu_pkg::OFS_CTRL) begin
      for (int i = 0; i < 3; i++) begin
        if (AVS_BYTEENABLE[i]) begin
          ctrl_q[i*8 +: 8] <= AVS_WRITEDATA[i*8 +: 8];
        end
      end
    end
  end

  always_ff @(posedge CLK_SYS) begin
    if (SRST) begin
      rdata_q <= 32'h0000_0000;
    end else if (req_act && AVS_READ) begin
      case (AVS_ADDRESS)
        alu_pkg::OFS_CTRL: rdata_q <= {8'h00, ctrl_q[23:0]};
        alu_pkg::OFS_WORK: rdata_q <= {24'h000000, work_q};
        alu_pkg::OFS_STATUS: rdata_q <= {28'h0000000, file_we_q, zero_q,
                                         digit_carry_flag_q, carry_q};
        alu_pkg::OFS_FILE_OUT: rdata_q <= {24'h000000, file_wdata_q};
        default: rdata_q <= 32'h0000_0000;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign WORK = work_q;
  assign CARRY = carry_q;
  assign DIGIT_CARRY = digit_carry_flag_q;
  assign ZERO = zero_q;
  assign FILE_WE = file_we_q;
  assign FILE_WDATA = file_wdata_q;
  assign AVS_READDATA = rdata_q;
  assign AVS_WAITREQUEST = ~ack_q;
endmodule // byte_alu_sub_xor_swap
`default_nettype wire

// ===== test/alu_assertions.sv
// checker: datapath and flag relations at the slice ports
`timescale 1ns/1ps
`default_nettype none
module alu_assertions (
  // clock and reset
  input wire logic CLK_SYS,
  input wire logic SRST,
  // decoder side
  input wire logic OP_VALID,
  input wire logic [2:0] OP_CODE,
  input wire logic OP_DEST,
  input wire logic [7:0] OP_LITERAL,
  input wire logic [7:0] FILE_RDATA,
  // results
  input wire logic FILE_WE,
  input wire logic [7:0] FILE_WDATA,
  input wire logic [7:0] WORK,
  input wire logic CARRY,
  input wire logic DIGIT_CARRY,
  input wire logic ZERO
);
  logic [7:0] opnd;
  // of the two subtracts, only the literal one takes its operand from the instruction
  assign opnd = (OP_CODE == 3'h2) ? OP_LITERAL : FILE_RDATA;
  default clocking @(posedge CLK_SYS); endclocking
  default disable iff (SRST);
  a_sub_work:
    assert property (OP_VALID && OP_CODE == 3'h1 && !OP_DEST |=> !FILE_WE &&
      WORK == $past(FILE_RDATA) - $past(WORK)) else $error("sub to work");
  a_sub_file:
    assert property (OP_VALID && OP_CODE == 3'h1 && OP_DEST |=> FILE_WE && $stable(WORK) &&
      FILE_WDATA == $past(FILE_RDATA) - $past(WORK)) else $error("sub to file");
  a_borrow_flags:
    assert property (OP_VALID && OP_CODE inside {3'h1, 3'h2} |=> CARRY == ($past(WORK) <=
      $past(opnd)) && DIGIT_CARRY == ($past(WORK[3:0]) <= $past(opnd[3:0])))
      else $error("borrow flags");
  a_xor_lit:
    assert property (OP_VALID && OP_CODE == 3'h3 |=> !FILE_WE && $stable({CARRY, DIGIT_CARRY})
      && WORK == ($past(WORK) ^ $past(OP_LITERAL))) else $error("xor literal");
  a_swap_nibble:
    assert property (OP_VALID && OP_CODE == 3'h5 |=> $stable({CARRY, DIGIT_CARRY, ZERO}) &&
      ($past(OP_DEST) ? FILE_WDATA : WORK) == {$past(FILE_RDATA[3:0]), $past(FILE_RDATA[7:4])})
      else $error("swap");
  a_xor_file:
    assert property (OP_VALID && OP_CODE == 3'h4 |=> FILE_WE == $past(OP_DEST) &&
      ($past(OP_DEST) ? FILE_WDATA : WORK) == ($past(WORK) ^ $past(FILE_RDATA)) &&
      $stable({CARRY, DIGIT_CARRY})) else $error("xor file");
  a_sub_lit:
    assert property (OP_VALID && OP_CODE == 3'h2 |=> !FILE_WE &&
      WORK == $past(OP_LITERAL) - $past(WORK)) else $error("sub literal");
  a_zero_result:
    assert property (OP_VALID && OP_CODE inside {[3'h1:3'h4]} |=>
      ZERO == ((FILE_WE ? FILE_WDATA : WORK) == 8'h00)) else $error("zero flag");
  cover property (FILE_WE);
  cover property (OP_VALID && OP_CODE == 3'h5 && !OP_DEST);
  cover property (OP_VALID ##1 OP_VALID && OP_CODE == 3'h1);
endmodule // alu_assertions
bind byte_alu_sub_xor_swap alu_assertions chk (.CLK_SYS(CLK_SYS), .SRST(SRST),
  .OP_VALID(OP_VALID), .OP_CODE(OP_CODE), .OP_DEST(OP_DEST), .OP_LITERAL(OP_LITERAL),
  .FILE_RDATA(FILE_RDATA), .FILE_WE(FILE_WE), .FILE_WDATA(FILE_WDATA), .WORK(WORK),
  .CARRY(CARRY), .DIGIT_CARRY(DIGIT_CARRY), .ZERO(ZERO));
`default_nettype wire

// ===== test/file_model.sv
// far-side model: one file register read by the slice and written back
`timescale 1ns/1ps
`default_nettype none
module file_model (
  // clock
  input wire logic clk,
  // preload from the bench
  input wire logic load,
  input wire logic [7:0] load_val,
  // write-back from the slice
  input wire logic we,
  input wire logic [7:0] wdata,
  // value seen by the slice
  output logic [7:0] rdata
);
  // a preload wins over a write-back landing in the same cycle
  always_ff @(posedge clk) begin
    if (load) begin
      rdata <= load_val;
    end else if (we) begin
      rdata <= wdata;
    end
  end
endmodule // file_model
`default_nettype wire

// ===== test/byte_alu_sub_xor_swap_test.sv
// bench: op sequences and register accesses against a reference
`timescale 1ns/1ps
`default_nettype none
module byte_alu_sub_xor_swap_test;
  logic clk = 1'h0;
  logic srst = 1'h1;
  logic op_valid = 1'h0;
  logic op_dest = 1'h0;
  logic ld = 1'h0;
  logic av_rd = 1'h0;
  logic av_wr = 1'h0;
  logic [2:0] op_code = 3'h0;
  logic [7:0] op_lit = 8'h00;
  logic [7:0] ld_val = 8'h00;
  logic [3:0] av_addr = 4'h0;
  logic [31:0] av_wd = 32'h0;
  logic [31:0] av_q;
  logic [7:0] fwd, frd, work;
  logic av_wait, fwe, cy, dc, zf;
  logic [7:0] w_ref = 8'h00;
  logic [7:0] f_ref = 8'h00;
  logic [2:0] fl_ref = 3'h0;
  int err_count = 0;
  int n_tests = 0;
  // pairs of {work, file}: equal, and above and below in each nibble
  logic [15:0] pairs [4] = '{16'h5A5A, 16'h100F, 16'h0F10, 16'hFF00};
  always #5 clk = ~clk;
  byte_alu_sub_xor_swap uut (.CLK_SYS(clk), .SRST(srst), .OP_VALID(op_valid), .OP_CODE(op_code),
    .OP_DEST(op_dest), .OP_LITERAL(op_lit), .FILE_RDATA(frd), .FILE_WE(fwe), .FILE_WDATA(fwd),
    .WORK(work), .CARRY(cy), .DIGIT_CARRY(dc), .ZERO(zf), .AVS_ADDRESS(av_addr),
    .AVS_READ(av_rd), .AVS_WRITE(av_wr), .AVS_WRITEDATA(av_wd), .AVS_BYTEENABLE(4'hF),
    .AVS_READDATA(av_q), .AVS_WAITREQUEST(av_wait));
  file_model fm (.clk(clk), .load(ld), .load_val(ld_val), .we(fwe), .wdata(fwd), .rdata(frd));
  task final_report;
    if (err_count == 0 && n_tests > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  task chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      err_count++;
      $display("FAIL %0t got %h exp %h", $time, got, exp);
    end
  endtask
  // reference step: returns {file write, result}, updates work, file and flags
  function automatic logic [8:0] step(input logic [2:0] c, input logic d, input logic [7:0] k);
    logic [7:0] a;
    logic [7:0] r;
    logic wr;
    a = (c == 3'h2 || c == 3'h3) ? k : f_ref;
    case (c)
      3'h1, 3'h2: r = a - w_ref;
      3'h3, 3'h4: r = a ^ w_ref;
      3'h5: r = {a[3:0], a[7:4]};
      default: r = w_ref;
    endcase
    if (c == 3'h1 || c == 3'h2) begin
      fl_ref[1:0] = {w_ref[3:0] <= a[3:0], w_ref <= a};
    end
    if (c inside {[3'h1:3'h4]}) begin
      fl_ref[2] = (r == 8'h00);
    end
    wr = d && c inside {3'h1, 3'h4, 3'h5};
    if (wr) begin
      f_ref = r;
    end else if (c inside {[3'h1:3'h5]}) begin
      w_ref = r;
    end
    return {wr, r};
  endfunction
  // leaves the strobe up so that ops may follow back to back
  task automatic op(input logic [2:0] c, input logic d, input logic [7:0] k);
    logic [8:0] s;
    logic [11:0] e;
    s = step(c, d, k);
    e = {w_ref, fl_ref, s[8]};
    op_valid <= 1'h1;
    op_code <= c;
    op_dest <= d;
    op_lit <= k;
    @(posedge clk);
    fork
      #1 chk({12'h0, s[8] ? fwd : 8'h00, work, zf, dc, cy, fwe}, {12'h0, s[8] ? s[7:0] : 8'h00, e});
    join_none
  endtask
  task setf(input logic [7:0] v);
    op_valid <= 1'h0;
    ld <= 1'h1;
    ld_val <= v;
    f_ref = v;
    @(posedge clk);
    ld <= 1'h0;
  endtask
  task bus(input logic wr, input logic [3:0] a, input logic [31:0] d, input logic [31:0] exp);
    int i;
    op_valid <= 1'h0;
    @(posedge clk);
    av_addr <= a;
    av_wr <= wr;
    av_rd <= !wr;
    av_wd <= d;
    i = 0;
    do begin
      @(posedge clk);
      i++;
    end while (av_wait !== 1'h0 && i < 40);
    if (av_wait !== 1'h0) begin
      err_count++;
      final_report;
    end
    if (!wr) begin
      chk(av_q, exp);
    end
    av_rd <= 1'h0;
    av_wr <= 1'h0;
  endtask
  initial begin
    repeat (8) @(posedge clk);
    srst <= 1'h0;
    bus(1'h0, 4'h4, 32'h0, 32'h0);
    bus(1'h0, 4'h8, 32'h0, 32'h0);
    bus(1'h1, 4'h4, 32'h5A, 32'h0);
    w_ref = 8'h5A;
    bus(1'h0, 4'h4, 32'h0, 32'h5A);
    bus(1'h1, 4'h1, 32'hFF, 32'h0);
    bus(1'h0, 4'h1, 32'h0, 32'h0);
    foreach (pairs[i]) begin
      setf(pairs[i][7:0]);
      op(3'h3, 1'h1, w_ref ^ pairs[i][15:8]);
      op(3'h1, 1'h0, 8'h00);
      op(3'h2, 1'h1, pairs[i][7:0]);
    end
    op(3'h1, 1'h1, 8'h00);
    bus(1'h0, 4'hC, 32'h0, {24'h0, f_ref});
    op(3'h4, 1'h1, 8'h00);
    bus(1'h0, 4'hC, 32'h0, {24'h0, f_ref});
    op(3'h4, 1'h0, 8'h00);
    op(3'h5, 1'h0, 8'h00);
    op(3'h5, 1'h1, 8'h00);
    bus(1'h0, 4'hC, 32'h0, {24'h0, f_ref});
    setf(w_ref);
    op(3'h4, 1'h0, 8'h00);
    op(3'h0, 1'h1, 8'hFF);
    op(3'h6, 1'h1, 8'hFF);
    op(3'h7, 1'h1, 8'hFF);
    bus(1'h1, 4'h0, 32'h0033_7702, 32'h0);
    bus(1'h1, 4'h0, 32'h0133_7702, 32'h0);
    void'(step(3'h2, 1'h0, 8'h77));
    bus(1'h0, 4'h4, 32'h0, {24'h0, w_ref});
    bus(1'h0, 4'h8, 32'h0, {29'h0, fl_ref});
    // go is write-only and reads back as zero
    bus(1'h0, 4'h0, 32'h0, 32'h0033_7702);
    // mid-run reset: work, flags and write-back data return to zero
    srst <= 1'h1;
    repeat (2) @(posedge clk);
    srst <= 1'h0;
    w_ref = 8'h00;
    fl_ref = 3'h0;
    bus(1'h0, 4'h4, 32'h0, 32'h0);
    bus(1'h0, 4'h8, 32'h0, 32'h0);
    bus(1'h0, 4'hC, 32'h0, 32'h0);
    final_report;
  end
  initial begin
    #100000;
    err_count++;
    final_report;
  end
endmodule // byte_alu_sub_xor_swap_test
`default_nettype wire
